// File: ttpgc_checker.sv
/*
  Pattern checker: self-synchronising PRBS7/PRBS31 check and 64-bit
  reference-pattern alignment, sync tracking and check window.
  Assumes data arrives one bit per clock, already polarity-corrected,
  from logic on the same clock.
*/
module ttpgc_checker
  import ttpgc_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // configuration
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_mask,
  input  wire logic [1:0]  i_window,
  input  wire logic [63:0] i_ref,
  // data
  input  wire logic        i_data,
  // status
  output logic             o_locked,
  output logic             o_err,
  output logic             o_sync_loss,
  output logic             o_win_done
);

  ttpgc_chk_state_t state_q;
  logic [2:0]  mode_q;
  logic [30:0] hist_q;
  logic [5:0]  idx_q;
  logic [6:0]  match_q;
  logic [5:0]  span_q;
  logic [2:0]  errs_q;
  logic [39:0] bits_q;
  logic        dec_bit;
  logic        exp_bit;
  logic        miss;
  logic        restart;
  logic [39:0] limit;

  // ---------------------------------------------------------------
  // prediction
  // ---------------------------------------------------------------
  always_comb begin
    // prbs31 arrives inverted; undo it before it enters the history
    dec_bit = (i_mode == MODE_PRBS31) ? ~i_data : i_data;
    case (i_mode)
      MODE_PRBS7:  exp_bit = hist_q[6] ^ hist_q[5];
      MODE_PRBS31: exp_bit = hist_q[30] ^ hist_q[27];
      MODE_USER:   exp_bit = i_ref[idx_q];
      default:     exp_bit = 1'b0;
    endcase
    miss    = exp_bit != dec_bit;
    restart = (i_mode != mode_q) || !mode_is_on(i_mode);
    case (i_window)
      WIN_20:  limit = WIN_LIMIT_20;
      WIN_30:  limit = WIN_LIMIT_30;
      default: limit = WIN_LIMIT_40;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hist_q <= 31'h0;
      mode_q <= MODE_OFF;
    end else begin
      hist_q <= {hist_q[29:0], dec_bit};
      mode_q <= i_mode;
    end
  end

  // ---------------------------------------------------------------
  // sync state machine
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q     <= CHK_IDLE;
      idx_q       <= 6'h00;
      match_q     <= 7'h00;
      span_q      <= 6'h00;
      errs_q      <= 3'h0;
      bits_q      <= 40'h0;
      o_locked    <= 1'b0;
      o_err       <= 1'b0;
      o_sync_loss <= 1'b0;
      o_win_done  <= 1'b0;
    end else begin
      o_err       <= 1'b0;
      o_sync_loss <= 1'b0;
      if (restart) begin
        state_q    <= CHK_IDLE;
        o_locked   <= 1'b0;
        o_win_done <= 1'b0;
      end else begin
        case (state_q)
          CHK_IDLE: begin
            state_q <= CHK_HUNT;
            idx_q   <= 6'h00;
            match_q <= 7'h00;
          end
          CHK_HUNT: begin
            if (miss) begin
              match_q <= 7'h00;
              // holding the index slips the reference by one bit
              if (i_mode != MODE_USER) begin
                idx_q <= idx_q + 6'h01;
              end
            end else begin
              idx_q   <= idx_q + 6'h01;
              match_q <= match_q + 7'h01;
              if (match_q == SYNC_MATCH_N - 7'h01) begin
                state_q    <= CHK_LOCK;
                o_locked   <= 1'b1;
                span_q     <= 6'h00;
                errs_q     <= 3'h0;
                bits_q     <= 40'h0;
                o_win_done <= 1'b0;
              end
            end
          end
          CHK_LOCK: begin
            idx_q  <= idx_q + 6'h01;
            span_q <= span_q + 6'h01;
            if (span_q == LOSS_SPAN_LAST) begin
              errs_q <= 3'h0;
            end else if (miss) begin
              errs_q <= errs_q + 3'h1;
            end
            if (i_window == WIN_CONT) begin
              o_win_done <= 1'b0;
              o_err      <= miss;
            end else if (!o_win_done) begin
              o_err  <= miss;
              bits_q <= bits_q + 40'h1;
              if (bits_q == limit - 40'h1) begin
                o_win_done <= 1'b1;
              end
            end
            if (miss && (errs_q == LOSS_ERR_N - 3'h1) && !i_mask) begin
              state_q     <= CHK_HUNT;
              o_locked    <= 1'b0;
              o_sync_loss <= 1'b1;
              match_q     <= 7'h00;
              // a resync restarts the window, so a stale done flag cannot
              // outlive the lock it belonged to
              o_win_done  <= 1'b0;
            end
            // with the mask set the lock is kept whatever the error rate
          end
          default: begin
            state_q  <= CHK_IDLE;
            o_locked <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// File: ttpgc_line_model.sv
/*
  Serial line model: carries the generated bit stream back into the checker
  input, and corrupts one bit for each clock in which i_flip is high.
  Assumes the bench raises i_flip just after a rising edge of i_mclk.
*/
module ttpgc_line_model (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // line
  input  wire logic i_tx_bit,
  input  wire logic i_flip,
  output logic      o_rx_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  // one register stage stands in for the path delay; the checker must not
  // care about the alignment it causes
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_bit <= 1'b0;
    end else begin
      o_rx_bit <= i_tx_bit ^ i_flip;
    end
  end
endmodule

// File: ttpgc_pkg.sv
/*
  Constants, register map and shared types of the transmit test-pattern
  generator and checker.
  Assumes a single 250 MHz clock, one serial bit per clock cycle.
*/
package ttpgc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TEST_PATTERN_SELECT    = 8'h9D;
  localparam logic [7:0] ADDR_PATTERN_CHECKER_CONFIG = 8'h9E;
  localparam logic [7:0] ADDR_USER_PATTERN_BYTE_ZERO = 8'h9F;

  localparam logic [7:0] RST_TEST_PATTERN_SELECT     = 8'h00;
  localparam logic [7:0] RST_PATTERN_CHECKER_CONFIG  = 8'h02;
  localparam logic [7:0] RST_USER_PATTERN_VALUE      = 8'hAA;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEL_CHK_INV_BIT = 7;
  localparam int SEL_CHK_LSB     = 4;
  localparam int SEL_GEN_INV_BIT = 3;
  localparam int SEL_GEN_LSB     = 0;
  localparam int CFG_MASK_BIT    = 2;
  localparam int CFG_WIN_LSB     = 0;
  localparam logic [7:0] CFG_USED_BITS = 8'h07;

  // ---------------------------------------------------------------
  // modes and windows
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_PRBS7  = 3'h1;
  localparam logic [2:0] MODE_PRBS31 = 3'h2;
  localparam logic [2:0] MODE_USER   = 3'h3;

  localparam logic [1:0]  WIN_CONT     = 2'h0;
  localparam logic [1:0]  WIN_20       = 2'h1;
  localparam logic [1:0]  WIN_30       = 2'h2;
  localparam logic [39:0] WIN_LIMIT_20 = 40'h00000FFC00;
  localparam logic [39:0] WIN_LIMIT_30 = 40'h003FFFFC00;
  localparam logic [39:0] WIN_LIMIT_40 = 40'hFFFFFFFC00;

  // ---------------------------------------------------------------
  // pattern and sync constants
  // ---------------------------------------------------------------
  localparam logic [30:0] PRBS_SEED       = 31'h7FFFFFFF;
  // upper pattern bytes are not writable here and keep their reset value
  localparam logic [55:0] USER_UPPER_FILL = 56'hAAAAAAAAAAAAAA;
  localparam logic [6:0]  SYNC_MATCH_N    = 7'h40;
  localparam logic [5:0]  LOSS_SPAN_LAST  = 6'h3F;
  localparam logic [2:0]  LOSS_ERR_N      = 3'h4;

  typedef enum logic [2:0] {
    CHK_IDLE = 3'b001,
    CHK_HUNT = 3'b010,
    CHK_LOCK = 3'b100
  } ttpgc_chk_state_t;

  function automatic logic mode_is_on(input logic [2:0] m);
    mode_is_on = (m == MODE_PRBS7) || (m == MODE_PRBS31) || (m == MODE_USER);
  endfunction

endpackage

// File: ttpgc_top.sv
/*
  Transmit test-pattern generator and checker with its three byte
  registers on the configuration register port.
  Assumes the register port and the serial data come from logic on i_mclk;
  the checker reference pattern is held in registers outside this block.
*/
// Functional notes
// - checker invert bit inverts all checker input
// - checker mode: off, PRBS7, PRBS31, user
// - generator invert bit inverts emitted pattern
// - generator mode picks PRBS7, PRBS31 or user
// - generator mode zero emits no pattern
// - PRBS31 emitted in inverted polarity
// - unmasked sync loss reported, checker resynchronises
// - masked: no loss report, no reset after lock
// - window code zero checks continuously
// - windows of 2^20/30/40 minus 1024 bits
// - user pattern sent LSB first
// - byte zero holds pattern bits 7:0
// - user byte resets to 0xAA
module ttpgc_top
  import ttpgc_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  // generator output
  output logic             o_tx_bit,
  output logic             o_tx_active,
  // checker input and status
  input  wire logic        i_rx_bit,
  input  wire logic [63:0] i_chk_ref_pattern,
  output logic             o_chk_locked,
  output logic             o_chk_error,
  output logic             o_chk_sync_loss,
  output logic             o_chk_win_done
);

  logic [7:0]  sel_q;
  logic [7:0]  cfg_q;
  logic [7:0]  user_byte_q;
  logic [30:0] lfsr_q;
  logic [5:0]  idx_q;
  logic [2:0]  gen_prev_q;
  logic [3:0]  gen_cfg_prev_q;
  logic [5:0]  gen_run_q;
  logic [2:0]  gen_sel;
  logic        gen_inv;
  logic [2:0]  chk_sel;
  logic        chk_inv;
  logic        chk_mask;
  logic [1:0]  chk_win;
  logic [63:0] user_pat;
  logic        gen_raw;
  logic        gen_reseed;
  logic        chk_data;

  assign gen_sel  = sel_q[SEL_GEN_LSB +: 3];
  assign gen_inv  = sel_q[SEL_GEN_INV_BIT];
  assign chk_sel  = sel_q[SEL_CHK_LSB +: 3];
  assign chk_inv  = sel_q[SEL_CHK_INV_BIT];
  assign chk_mask = cfg_q[CFG_MASK_BIT];
  assign chk_win  = cfg_q[CFG_WIN_LSB +: 2];
  assign user_pat = {USER_UPPER_FILL, user_byte_q};
  assign chk_data = i_rx_bit ^ chk_inv;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q       <= RST_TEST_PATTERN_SELECT;
      cfg_q       <= RST_PATTERN_CHECKER_CONFIG;
      user_byte_q <= RST_USER_PATTERN_VALUE;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_TEST_PATTERN_SELECT:    sel_q       <= i_reg_wdata;
        ADDR_PATTERN_CHECKER_CONFIG: cfg_q       <= i_reg_wdata & CFG_USED_BITS;
        ADDR_USER_PATTERN_BYTE_ZERO: user_byte_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero; reserved bits are never stored
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_TEST_PATTERN_SELECT:    o_reg_rdata <= sel_q;
        ADDR_PATTERN_CHECKER_CONFIG: o_reg_rdata <= cfg_q;
        ADDR_USER_PATTERN_BYTE_ZERO: o_reg_rdata <= user_byte_q;
        default:                     o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // generator
  // ---------------------------------------------------------------
  always_comb begin
    gen_reseed = (gen_sel != gen_prev_q) || !mode_is_on(gen_sel);
    case (gen_sel)
      MODE_PRBS7:  gen_raw = lfsr_q[6];
      MODE_PRBS31: gen_raw = ~lfsr_q[30];
      MODE_USER:   gen_raw = user_pat[idx_q];
      default:     gen_raw = 1'b0;
    endcase
  end

  // both sequences share one shift register; any change of generator mode
  // reseeds it, so a direct PRBS31 to PRBS7 switch needs no disabled code between
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lfsr_q      <= PRBS_SEED;
      idx_q       <= 6'h00;
      gen_prev_q  <= MODE_OFF;
      o_tx_bit    <= 1'b0;
      o_tx_active <= 1'b0;
    end else begin
      gen_prev_q <= gen_sel;
      if (gen_reseed) begin
        lfsr_q      <= PRBS_SEED;
        idx_q       <= 6'h00;
        o_tx_bit    <= 1'b0;
        o_tx_active <= 1'b0;
      end else begin
        o_tx_bit    <= gen_raw ^ gen_inv;
        o_tx_active <= 1'b1;
        case (gen_sel)
          MODE_PRBS7:  lfsr_q[6:0] <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
          MODE_PRBS31: lfsr_q <= {lfsr_q[29:0], lfsr_q[30] ^ lfsr_q[27]};
          MODE_USER:   idx_q  <= idx_q + 6'h01;
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checker
  // ---------------------------------------------------------------
  ttpgc_checker i_ttpgc_checker (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_mode      (chk_sel),
    .i_mask      (chk_mask),
    .i_window    (chk_win),
    .i_ref       (i_chk_ref_pattern),
    .i_data      (chk_data),
    .o_locked    (o_chk_locked),
    .o_err       (o_chk_error),
    .o_sync_loss (o_chk_sync_loss),
    .o_win_done  (o_chk_win_done)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // cycles since generator setting last changed, saturating
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      gen_cfg_prev_q <= 4'h0;
      gen_run_q      <= 6'h00;
    end else begin
      gen_cfg_prev_q <= sel_q[3:0];
      if (sel_q[3:0] != gen_cfg_prev_q || !o_tx_active) begin
        gen_run_q <= 6'h00;
      end else if (gen_run_q != 6'h3F) begin
        gen_run_q <= gen_run_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_gen_off_idle: assert property ((gen_sel == MODE_OFF) |=> (!o_tx_active && !o_tx_bit))
    else $error("generator active while disabled");

  a_user_lsb_first: assert property (($rose(o_tx_active) && gen_sel == MODE_USER && !gen_inv)
    |-> (o_tx_bit == user_pat[0] ##1 o_tx_bit == user_pat[1]))
    else $error("user pattern not sent lsb first");

  a_gen_invert_user: assert property (($rose(o_tx_active) && gen_sel == MODE_USER && gen_inv)
    |-> o_tx_bit == !user_byte_q[0])
    else $error("generator invert not applied");

  a_prbs7_recur: assert property ((gen_run_q == 6'h3F && gen_sel == MODE_PRBS7 && !gen_inv
    && sel_q[3:0] == gen_cfg_prev_q)
    |-> o_tx_bit == ($past(o_tx_bit, 7) ^ $past(o_tx_bit, 6)))
    else $error("prbs7 recurrence broken");

  a_prbs31_polarity: assert property ((gen_run_q == 6'h3F && gen_sel == MODE_PRBS31 && !gen_inv
    && sel_q[3:0] == gen_cfg_prev_q)
    |-> o_tx_bit == !($past(o_tx_bit, 31) ^ $past(o_tx_bit, 28)))
    else $error("prbs31 polarity or recurrence wrong");

  a_chk_off_unlock: assert property ((chk_sel == MODE_OFF) |=> !o_chk_locked)
    else $error("checker locked while disabled");

  a_mask_keeps_lock: assert property ((o_chk_locked && chk_mask && $stable(chk_sel))
    |=> (o_chk_locked && !o_chk_sync_loss))
    else $error("masked checker lost lock");

  a_loss_resets: assert property (o_chk_sync_loss
    |-> (!o_chk_locked && $past(o_chk_locked) && !$past(chk_mask)))
    else $error("sync loss without reset or while masked");

  a_window_cont: assert property (o_chk_win_done |-> $past(chk_win) != WIN_CONT)
    else $error("window ended in continuous mode");

endmodule

// File: ttpgc_top_tb_top.sv
/*
  Self-checking bench of the transmit test-pattern generator and checker.
  Assumes the line model loops the generator output back to the checker.
*/
module ttpgc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ttpgc_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        mclk      = 1'b0;
  logic        nrst      = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [63:0] chk_ref   = 64'h0;
  logic        flip      = 1'b0;
  logic [7:0]  rdata;
  logic        tx_bit;
  logic        tx_active;
  logic        rx_bit;
  logic        locked;
  logic        chk_error;
  logic        sync_loss;
  logic        win_done;
  int          num_errors   = 0;
  int          total_checks = 0;

  always #2 mclk = ~mclk;

  ttpgc_top i_ttpgc_top (
    .i_mclk(mclk), .i_nrst(nrst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .o_tx_bit(tx_bit),
    .o_tx_active(tx_active), .i_rx_bit(rx_bit), .i_chk_ref_pattern(chk_ref),
    .o_chk_locked(locked), .o_chk_error(chk_error), .o_chk_sync_loss(sync_loss),
    .o_chk_win_done(win_done)
  );

  ttpgc_line_model i_ttpgc_line_model (
    .i_mclk(mclk), .i_nrst(nrst), .i_tx_bit(tx_bit), .i_flip(flip), .o_rx_bit(rx_bit)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    chk($sformatf("register %0h", a), {56'h0, e}, {56'h0, rdata});
  endtask

  // the generator is always parked at code zero first, which also keeps
  // every step from the 31-bit to the 7-bit sequence legal
  task automatic select(input logic [7:0] v);
    write_reg(ADDR_TEST_PATTERN_SELECT, 8'h00);
    repeat (4) @(posedge mclk);
    write_reg(ADDR_TEST_PATTERN_SELECT, v);
  endtask

  task automatic grab(input int n, output logic [63:0] b);
    int k;
    k = 0;
    b = '0;
    while (tx_active !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    for (int i = 0; i < n; i++) begin
      b[i] = tx_bit;
      @(negedge mclk);
    end
  endtask

  task automatic lock_within(input int lim, input logic e);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge mclk);
      ok = (locked === 1'b1);
    end
    chk("checker lock", {63'h0, e}, {63'h0, ok});
  endtask

  task automatic flips(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      flip <= 1'b1;
      @(posedge mclk);
      flip <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask

  task automatic watch(input int cyc, output int ne, output int nl);
    ne = 0;
    nl = 0;
    repeat (cyc) begin
      @(negedge mclk);
      ne += (chk_error === 1'b1);
      nl += (sync_loss === 1'b1);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [63:0] b;
    logic [63:0] pat;
    int          bad;
    int          ne;
    int          nl;
    pat = {USER_UPPER_FILL, 8'h3C};
    repeat (6) @(posedge mclk);
    nrst    <= 1'b1;
    chk_ref <= pat;
    check_reg(ADDR_TEST_PATTERN_SELECT, RST_TEST_PATTERN_SELECT);
    check_reg(ADDR_PATTERN_CHECKER_CONFIG, 8'h02);
    check_reg(ADDR_USER_PATTERN_BYTE_ZERO, 8'hAA);
    check_reg(8'hA0, 8'h00);
    write_reg(ADDR_PATTERN_CHECKER_CONFIG, 8'hFF);
    check_reg(ADDR_PATTERN_CHECKER_CONFIG, 8'h07);
    write_reg(ADDR_PATTERN_CHECKER_CONFIG, 8'h00);
    write_reg(ADDR_USER_PATTERN_BYTE_ZERO, 8'h3C);
    check_reg(ADDR_USER_PATTERN_BYTE_ZERO, 8'h3C);
    $display("test registers done");

    select(8'h03);
    grab(64, b);
    chk("user pattern", pat, b);
    select(8'h0B);
    grab(64, b);
    chk("inverted user pattern", ~pat, b);
    write_reg(ADDR_TEST_PATTERN_SELECT, 8'h00);
    repeat (4) @(negedge mclk);
    chk("idle output", 64'h0, {62'h0, tx_active, tx_bit});
    select(8'h04);
    repeat (8) @(negedge mclk);
    chk("reserved code idle", 64'h0, {62'h0, tx_active, tx_bit});
    $display("test user pattern done");

    select(8'h01);
    grab(40, b);
    bad = 0;
    for (int n = 7; n < 40; n++) bad += (b[n] !== (b[n-7] ^ b[n-6]));
    chk("short sequence", 64'h0, 64'(bad));
    select(8'h02);
    grab(40, b);
    bad = 0;
    for (int n = 31; n < 40; n++) bad += (b[n] !== ~(b[n-31] ^ b[n-28]));
    chk("long sequence", 64'h0, 64'(bad));
    $display("test sequences done");

    for (int m = 1; m < 4; m++) begin
      select({1'b0, 3'(m), 1'b0, 3'(m)});
      lock_within(6000, 1'b1);
    end
    select(8'h01);
    lock_within(300, 1'b0);
    select(8'h99);
    lock_within(600, 1'b1);
    select(8'h91);
    lock_within(300, 1'b0);
    $display("test checker modes done");

    select(8'h11);
    lock_within(600, 1'b1);
    fork
      flips(1, 0);
      watch(40, ne, nl);
    join
    chk("single flip reported", 64'h1, {63'h0, ne > 0});
    chk("single flip keeps sync", 64'h0, 64'(nl));
    chk("window stays open", 64'h0, {63'h0, win_done});
    fork
      flips(4, 3);
      watch(60, ne, nl);
    join
    chk("loss of sync pulses", 64'h1, 64'(nl));
    lock_within(600, 1'b1);
    write_reg(ADDR_PATTERN_CHECKER_CONFIG, 8'h04);
    fork
      flips(4, 3);
      watch(60, ne, nl);
    join
    chk("masked loss", 64'h0, 64'(nl));
    chk("masked lock held", 64'h1, {63'h0, locked});
    // one full error span passes so the loss count starts from zero
    repeat (64) @(posedge mclk);
    write_reg(ADDR_PATTERN_CHECKER_CONFIG, 8'h01);
    fork
      flips(1, 0);
      watch(40, ne, nl);
    join
    chk("windowed flip reported", 64'h1, {63'h0, ne > 0});
    chk("window still open", 64'h0, {62'h0, nl != 0, win_done});
    $display("test sync tracking done");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    $display("unexpected run length: expected end before 60000 cycles, seen none");
    conclude();
  end
endmodule
